// ### common/standby_pkg.sv
/*
 Shared constants for the standby wake controller: register map, reset
 values, wait counts and status mode codes.
 Assumes one 200 MHz clock and a byte-addressed plain register port.
*/
`default_nettype none
package standby_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   // Register byte offsets
   localparam logic [3:0] OFS_SETTLE = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   // Settle select field
   localparam int unsigned SEL_W = 3;
   localparam int unsigned SEL_LSB = 0;
   localparam logic [2:0] SEL_RST = 3'h4;
   localparam logic [2:0] SEL_MAX = 3'h4;
   // Status fields
   localparam int unsigned STAT_MODE_LSB = 0;
   localparam int unsigned STAT_SVC_BIT = 2;
   localparam int unsigned STAT_RSTP_BIT = 3;
   // Light-sleep wake waits and deep-sleep settle base, in clocks
   localparam logic [15:0] HALT_SVC_WAIT = 16'h0008;
   localparam logic [15:0] HALT_NEXT_WAIT = 16'h0002;
   localparam logic [15:0] SETTLE_BASE_DEF = 16'h0800;
   // Mode codes shown in the status register
   localparam logic [1:0] MODE_RUN = 2'h0;
   localparam logic [1:0] MODE_HALT = 2'h1;
   localparam logic [1:0] MODE_STOP = 2'h2;
   localparam logic [1:0] MODE_WAIT = 2'h3;
   typedef enum logic [2:0] {ST_RUN, ST_HALT, ST_STOP, ST_WAIT} state_t;
endpackage
`default_nettype wire

// ### common/standby_link_if.sv
/*
 Internal carrier between the wake evaluator, the wait counter and the
 sequencer. Purely combinational grouping, no logic.
*/
`default_nettype none
interface standby_link_if #(parameter int unsigned CNT_W = 16);
   logic wake;
   logic service;
   logic load;
   logic [CNT_W-1:0] load_val;
   logic done;
   modport eval (output wake, output service);
   modport timer (input load, input load_val, output done);
   modport ctl (input wake, input service, input done, output load, output load_val);
endinterface
`default_nettype wire

// ### src/wake_eval.sv
/*
 Combinational wake and acknowledge decision over all request sources.
 Assumes request, mask and priority vectors are synchronous to the clock.
*/
`default_nettype none
module wake_eval #(
   parameter int unsigned N_IRQ = 8
) (
   input wire logic [N_IRQ-1:0] irq_flag_i,
   input wire logic [N_IRQ-1:0] interrupt_mask_flag_i,
   input wire logic [N_IRQ-1:0] interrupt_priority_flag_i,
   input wire logic global_interrupt_enable_i,
   input wire logic in_service_priority_flag_i,
   standby_link_if.eval lnk
);
   logic [N_IRQ-1:0] unmasked;
   logic hi_req;
   logic lo_req;
   always_comb begin
      unmasked = irq_flag_i & ~interrupt_mask_flag_i;
      hi_req = |(unmasked & ~interrupt_priority_flag_i);
      lo_req = |(unmasked & interrupt_priority_flag_i);
      // Masked requests never wake; evaluated same cycle so entry can be refused
      lnk.wake = |unmasked;
      lnk.service = (hi_req & global_interrupt_enable_i)
         | (lo_req & global_interrupt_enable_i & in_service_priority_flag_i);
   end
endmodule
`default_nettype wire

// ### src/settle_timer.sv
/*
 Down counter for every standby wait. A load restarts it; done is high in
 the last counted cycle. Assumes load values of at least one.
*/
`default_nettype none
module settle_timer #(
   parameter int unsigned CNT_W = 16
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   standby_link_if.timer lnk
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   always_comb begin
      cnt_d = cnt_q;
      if (lnk.load) begin
         cnt_d = lnk.load_val;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
   end
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   assign lnk.done = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) && !lnk.load;

   load_takes_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      lnk.load |=> cnt_q == $past(lnk.load_val))
      else $error("wait counter did not take load value");
endmodule
`default_nettype wire

// ### src/standby_wake_control.sv
/*
 Standby sequencer: light-sleep and deep-sleep entry, wake, waits, reset
 release, clock gating, peripheral run enables and port latch retention.
 Assumes halt and stop instruction strobes are one-cycle pulses from the
 CPU, and that the external reset input is already synchronous.
*/
// Added by the designer: the register offsets and the address-and-strobe port.
// Function
// - Unmasked request ends light-sleep; service if acknowledged, else next instruction.
// - Light-sleep wake to service waits 8 or 9 clocks.
// - Light-sleep wake without service waits 2 or 3 clocks.
// - External reset in light-sleep ends it with a normal reset.
// - High-priority unmasked request serviced only with global enable; masked keeps sleep.
// - Low-priority request serviced only with global enable and in-service flag.
// - Deep-sleep entered by instruction from either clock source.
// - Pending unmasked request at deep-sleep entry drops to settle wait then resumes.
// - Port output latches hold their value through deep-sleep.
// - Secondary timer runs in deep-sleep only on running timer output clock.
// - Async serial ports run in deep-sleep only on running timer output clock.
// - Clocked serial port runs in deep-sleep only on external serial clock.
// - Deep-sleep interrupt wake waits settle time, then services or continues.
// - External reset in deep-sleep resets after the settle time.
`default_nettype none
module standby_wake_control #(
   parameter int unsigned N_IRQ = 8,
   parameter int unsigned PORT_W = 8,
   parameter logic [15:0] SETTLE_BASE_CYC = standby_pkg::SETTLE_BASE_DEF
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic [standby_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [standby_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [standby_pkg::DATA_W-1:0] reg_rdata_o,
   input wire logic halt_cmd_i,
   input wire logic stop_cmd_i,
   input wire logic ext_reset_i,
   input wire logic [N_IRQ-1:0] irq_flag_i,
   input wire logic [N_IRQ-1:0] interrupt_mask_flag_i,
   input wire logic [N_IRQ-1:0] interrupt_priority_flag_i,
   input wire logic global_interrupt_enable_i,
   input wire logic in_service_priority_flag_i,
   input wire logic timer50_run_i,
   input wire logic timer_h_sel_tm_i,
   input wire logic uart_a_sel_tm_i,
   input wire logic uart_b_sel_tm_i,
   input wire logic csi_sel_ext_i,
   input wire logic port_we_i,
   input wire logic [PORT_W-1:0] port_wdata_i,
   output logic [PORT_W-1:0] port_latch_o,
   output logic cpu_clk_en_o,
   output logic main_crystal_clock_en_o,
   output logic secondary_timer_en_o,
   output logic async_port_a_en_o,
   output logic async_port_b_en_o,
   output logic clocked_serial_en_o,
   output logic vector_service_o,
   output logic resume_next_o,
   output logic reset_req_o,
   output logic [1:0] mode_o
);
   localparam int unsigned CW = standby_pkg::CNT_W;

   standby_link_if #(.CNT_W(CW)) lnk ();

   wake_eval #(.N_IRQ(N_IRQ)) u_eval (
      .irq_flag_i(irq_flag_i),
      .interrupt_mask_flag_i(interrupt_mask_flag_i),
      .interrupt_priority_flag_i(interrupt_priority_flag_i),
      .global_interrupt_enable_i(global_interrupt_enable_i),
      .in_service_priority_flag_i(in_service_priority_flag_i),
      .lnk(lnk.eval)
   );

   settle_timer #(.CNT_W(CW)) u_timer (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .lnk(lnk.timer)
   );

   function automatic logic [1:0] mode_code(input standby_pkg::state_t s);
      case (s)
         standby_pkg::ST_HALT: mode_code = standby_pkg::MODE_HALT;
         standby_pkg::ST_STOP: mode_code = standby_pkg::MODE_STOP;
         standby_pkg::ST_WAIT: mode_code = standby_pkg::MODE_WAIT;
         default: mode_code = standby_pkg::MODE_RUN;
      endcase
   endfunction

   // Off-window select values saturate rather than wrap to a short wait
   function automatic logic [CW-1:0] settle_cycles(input logic [2:0] sel);
      logic [2:0] s;
      s = (sel > standby_pkg::SEL_MAX) ? standby_pkg::SEL_MAX : sel;
      settle_cycles = CW'(SETTLE_BASE_CYC << s);
   endfunction

   standby_pkg::state_t state_q, state_d;
   logic svc_q, svc_d;
   logic rst_pend_q, rst_pend_d;
   logic [2:0] settle_sel_q, settle_sel_d;
   logic [PORT_W-1:0] port_q, port_d;
   logic [standby_pkg::DATA_W-1:0] rdata_q, rdata_d;
   logic vec_q, vec_d, next_q, next_d, rst_q, rst_d;
   logic cpu_q, cpu_d, xtal_q, xtal_d;
   logic h0_q, h0_d, ua_q, ua_d, ub_q, ub_d, csi_q, csi_d;
   logic [1:0] mode_q, mode_d;
   logic deep;
   logic tm_clk_ok;

   always_comb begin
      state_d = state_q;
      svc_d = svc_q;
      rst_pend_d = rst_pend_q;
      settle_sel_d = settle_sel_q;
      port_d = port_q;
      rdata_d = '0;
      vec_d = 1'b0;
      next_d = 1'b0;
      rst_d = 1'b0;
      lnk.load = 1'b0;
      lnk.load_val = '0;
      case (state_q)
         standby_pkg::ST_RUN: begin
            if (ext_reset_i) begin
               rst_d = 1'b1;
            end else if (stop_cmd_i) begin
               // Clock source plays no part in entry
               if (lnk.wake) begin
                  lnk.load = 1'b1;
                  lnk.load_val = settle_cycles(settle_sel_q);
                  svc_d = lnk.service;
                  state_d = standby_pkg::ST_WAIT;
               end else begin
                  state_d = standby_pkg::ST_STOP;
               end
            end else if (halt_cmd_i) begin
               if (lnk.wake) begin
                  lnk.load = 1'b1;
                  lnk.load_val = lnk.service ? standby_pkg::HALT_SVC_WAIT : standby_pkg::HALT_NEXT_WAIT;
                  svc_d = lnk.service;
                  state_d = standby_pkg::ST_WAIT;
               end else begin
                  state_d = standby_pkg::ST_HALT;
               end
            end
         end
         standby_pkg::ST_HALT: begin
            if (ext_reset_i) begin
               rst_d = 1'b1;
               state_d = standby_pkg::ST_RUN;
            end else if (lnk.wake) begin
               lnk.load = 1'b1;
               lnk.load_val = lnk.service ? standby_pkg::HALT_SVC_WAIT
                  : standby_pkg::HALT_NEXT_WAIT;
               svc_d = lnk.service;
               state_d = standby_pkg::ST_WAIT;
            end
         end
         standby_pkg::ST_STOP: begin
            if (ext_reset_i || lnk.wake) begin
               lnk.load = 1'b1;
               lnk.load_val = settle_cycles(settle_sel_q);
               rst_pend_d = ext_reset_i;
               svc_d = lnk.service;
               state_d = standby_pkg::ST_WAIT;
            end
         end
         standby_pkg::ST_WAIT: begin
            // A reset arriving mid-wait wins once the wait ends
            if (ext_reset_i) begin
               rst_pend_d = 1'b1;
            end
            if (lnk.done) begin
               rst_d = rst_pend_q | ext_reset_i;
               vec_d = !(rst_pend_q | ext_reset_i) && svc_q;
               next_d = !(rst_pend_q | ext_reset_i) && !svc_q;
               rst_pend_d = 1'b0;
               state_d = standby_pkg::ST_RUN;
            end
         end
         default: state_d = standby_pkg::ST_RUN;
      endcase
      if (reg_wr_i && reg_addr_i == standby_pkg::OFS_SETTLE) begin
         settle_sel_d = reg_wdata_i[standby_pkg::SEL_LSB +: standby_pkg::SEL_W];
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            standby_pkg::OFS_SETTLE: rdata_d[standby_pkg::SEL_LSB +: standby_pkg::SEL_W] = settle_sel_q;
            standby_pkg::OFS_STATUS: begin
               rdata_d[standby_pkg::STAT_MODE_LSB +: 2] = mode_q;
               rdata_d[standby_pkg::STAT_SVC_BIT] = svc_q;
               rdata_d[standby_pkg::STAT_RSTP_BIT] = rst_pend_q;
            end
            default: rdata_d = '0;
         endcase
      end
      deep = (state_d == standby_pkg::ST_STOP);
      tm_clk_ok = timer50_run_i;
      // Writes during deep-sleep are dropped so the pins keep their level
      if (port_we_i && !deep && state_q != standby_pkg::ST_STOP) begin
         port_d = port_wdata_i;
      end
      cpu_d = (state_d == standby_pkg::ST_RUN);
      xtal_d = !deep;
      h0_d = !deep || (timer_h_sel_tm_i && tm_clk_ok);
      ua_d = !deep || (uart_a_sel_tm_i && tm_clk_ok);
      ub_d = !deep || (uart_b_sel_tm_i && tm_clk_ok);
      csi_d = !deep || csi_sel_ext_i;
      mode_d = mode_code(state_d);
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_q <= standby_pkg::ST_RUN;
         svc_q <= 1'b0;
         rst_pend_q <= 1'b0;
         settle_sel_q <= standby_pkg::SEL_RST;
         port_q <= '0;
         rdata_q <= '0;
         vec_q <= 1'b0;
         next_q <= 1'b0;
         rst_q <= 1'b0;
         cpu_q <= 1'b1;
         xtal_q <= 1'b1;
         h0_q <= 1'b1;
         ua_q <= 1'b1;
         ub_q <= 1'b1;
         csi_q <= 1'b1;
         mode_q <= standby_pkg::MODE_RUN;
      end else begin
         state_q <= state_d;
         svc_q <= svc_d;
         rst_pend_q <= rst_pend_d;
         settle_sel_q <= settle_sel_d;
         port_q <= port_d;
         rdata_q <= rdata_d;
         vec_q <= vec_d;
         next_q <= next_d;
         rst_q <= rst_d;
         cpu_q <= cpu_d;
         xtal_q <= xtal_d;
         h0_q <= h0_d;
         ua_q <= ua_d;
         ub_q <= ub_d;
         csi_q <= csi_d;
         mode_q <= mode_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign port_latch_o = port_q;
   assign cpu_clk_en_o = cpu_q;
   assign main_crystal_clock_en_o = xtal_q;
   assign secondary_timer_en_o = h0_q;
   assign async_port_a_en_o = ua_q;
   assign async_port_b_en_o = ub_q;
   assign clocked_serial_en_o = csi_q;
   assign vector_service_o = vec_q;
   assign resume_next_o = next_q;
   assign reset_req_o = rst_q;
   assign mode_o = mode_q;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence halt_wake_s(logic svc);
      state_q == standby_pkg::ST_HALT && !ext_reset_i && lnk.wake && lnk.service == svc;
   endsequence
   // Eight reset-free wait edges; a reset on any of them replaces the pulse
   sequence quiet_s;
      !ext_reset_i [*8];
   endsequence

   halt_svc_wait_a: assert property (halt_wake_s(1'b1) ##1 quiet_s |=> vector_service_o)
      else $error("service wait after light-sleep not 8 clocks");
   halt_next_wait_a: assert property (halt_wake_s(1'b0) |-> ##3 resume_next_o)
      else $error("resume wait after light-sleep not 2 clocks");
   halt_reset_a: assert property (state_q == standby_pkg::ST_HALT && ext_reset_i
      |=> reset_req_o && state_q == standby_pkg::ST_RUN)
      else $error("reset did not end light-sleep");
   masked_hold_a: assert property (state_q == standby_pkg::ST_HALT && !lnk.wake && !ext_reset_i
      |=> state_q == standby_pkg::ST_HALT)
      else $error("light-sleep left without unmasked request");
   lowprio_gate_a: assert property (lnk.service && !(|(irq_flag_i & ~interrupt_mask_flag_i
      & ~interrupt_priority_flag_i)) |-> global_interrupt_enable_i && in_service_priority_flag_i)
      else $error("low priority request serviced without enables");
   stop_pend_a: assert property (state_q == standby_pkg::ST_RUN && stop_cmd_i && lnk.wake && !ext_reset_i
      |=> state_q == standby_pkg::ST_WAIT && lnk.done == 1'b0)
      else $error("pending request did not bypass deep-sleep");
   stop_clocks_a: assert property (state_q == standby_pkg::ST_STOP
      |-> !main_crystal_clock_en_o && !cpu_clk_en_o)
      else $error("clocks running in deep-sleep");
   port_hold_a: assert property (state_q == standby_pkg::ST_STOP |=> $stable(port_latch_o))
      else $error("port latch changed in deep-sleep");
   csi_gate_a: assert property (state_q == standby_pkg::ST_STOP && $past(state_q) == standby_pkg::ST_STOP
      |-> clocked_serial_en_o == $past(csi_sel_ext_i))
      else $error("clocked serial enable wrong in deep-sleep");
   stop_reset_a: assert property (state_q == standby_pkg::ST_STOP && ext_reset_i
      |=> rst_pend_q && state_q == standby_pkg::ST_WAIT && !cpu_clk_en_o)
      else $error("reset in deep-sleep skipped settle wait");
endmodule
`default_nettype wire

// ### sim/cpu_irq_model.sv
/*
 Behavioural CPU core and interrupt request sources facing the standby
 controller. Assumes the bench calls its tasks between clock edges.
*/
`default_nettype none
module cpu_irq_model (
   input wire logic ref_clk_i,
   output logic halt_cmd_o,
   output logic stop_cmd_o,
   output logic [7:0] irq_o,
   output logic [7:0] mask_o,
   output logic [7:0] prio_o,
   output logic ie_o,
   output logic isp_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      halt_cmd_o = 1'b0;
      stop_cmd_o = 1'b0;
      irq_o = 8'h00;
      mask_o = 8'hff;
      prio_o = 8'h00;
      ie_o = 1'b0;
      isp_o = 1'b0;
   end
   // One source only; the others stay masked so they never wake
   task automatic post(input logic [3:0] f);
      @(posedge ref_clk_i);
      irq_o <= 8'h08;
      mask_o <= {4'hf, f[3], 3'h7};
      prio_o <= {4'h0, f[2], 3'h0};
      ie_o <= f[1];
      isp_o <= f[0];
   endtask
   task automatic clear();
      @(posedge ref_clk_i);
      irq_o <= 8'h00;
   endtask
   task automatic do_halt();
      @(posedge ref_clk_i);
      halt_cmd_o <= 1'b1;
      @(posedge ref_clk_i);
      halt_cmd_o <= 1'b0;
   endtask
   // Either clock source behaves the same here, so no source is modelled
   task automatic do_stop();
      @(posedge ref_clk_i);
      stop_cmd_o <= 1'b1;
      @(posedge ref_clk_i);
      stop_cmd_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
/*
 Self-checking bench for the standby wake controller.
 Assumes a 200 MHz clock and a shortened settle base of four cycles.
*/
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] BASE = 16'h0004;
   localparam int S = 4;
   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic ext_reset_i = 1'b0;
   logic timer50_run_i = 1'b0;
   logic timer_h_sel_tm_i = 1'b0;
   logic uart_a_sel_tm_i = 1'b0;
   logic uart_b_sel_tm_i = 1'b0;
   logic csi_sel_ext_i = 1'b0;
   logic port_we_i = 1'b0;
   logic [7:0] port_wdata_i = 8'h00;
   logic halt_cmd, stop_cmd, ie, in_service_priority_flag;
   logic [7:0] irq, mask, prio, port_latch_o;
   logic [31:0] reg_rdata_o, rd_val;
   logic cpu_clk_en_o, xtal_en_o, sec_en_o, a_en_o, b_en_o, csi_en_o;
   logic vector_service_o, resume_next_o, reset_req_o;
   logic [1:0] mode_o;
   logic stop_seen = 1'b0;
   int error_cnt = 0;
   int n_checks = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) if (mode_o === standby_pkg::MODE_STOP) stop_seen <= 1'b1;
   cpu_irq_model cpu_u (.ref_clk_i(ref_clk_i), .halt_cmd_o(halt_cmd), .stop_cmd_o(stop_cmd), .irq_o(irq),
      .mask_o(mask), .prio_o(prio), .ie_o(ie), .isp_o(in_service_priority_flag));
   standby_wake_control #(.N_IRQ(8), .PORT_W(8), .SETTLE_BASE_CYC(BASE)) dut_u (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .halt_cmd_i(halt_cmd),
      .stop_cmd_i(stop_cmd), .ext_reset_i(ext_reset_i), .irq_flag_i(irq), .interrupt_mask_flag_i(mask),
      .interrupt_priority_flag_i(prio), .global_interrupt_enable_i(ie), .in_service_priority_flag_i(in_service_priority_flag),
      .timer50_run_i(timer50_run_i), .timer_h_sel_tm_i(timer_h_sel_tm_i), .uart_a_sel_tm_i(uart_a_sel_tm_i),
      .uart_b_sel_tm_i(uart_b_sel_tm_i), .csi_sel_ext_i(csi_sel_ext_i), .port_we_i(port_we_i),
      .port_wdata_i(port_wdata_i), .port_latch_o(port_latch_o), .cpu_clk_en_o(cpu_clk_en_o),
      .main_crystal_clock_en_o(xtal_en_o), .secondary_timer_en_o(sec_en_o), .async_port_a_en_o(a_en_o),
      .async_port_b_en_o(b_en_o), .clocked_serial_en_o(csi_en_o), .vector_service_o(vector_service_o),
      .resume_next_o(resume_next_o), .reset_req_o(reset_req_o), .mode_o(mode_o));
   task automatic stop_test();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      rd_val = reg_rdata_o;
   endtask
   task automatic port_wr(input logic [7:0] d);
      @(posedge ref_clk_i);
      port_we_i <= 1'b1;
      port_wdata_i <= d;
      @(posedge ref_clk_i);
      port_we_i <= 1'b0;
   endtask
   // Counts edges to the first result pulse; an external reset is one cycle long
   task automatic wait_res(output int n);
      n = 0;
      do begin
         @(posedge ref_clk_i);
         ext_reset_i <= 1'b0;
         #1;
         n++;
      end while (n < 200 && vector_service_o !== 1'b1 && resume_next_o !== 1'b1 && reset_req_o !== 1'b1);
   endtask
   function automatic logic [2:0] res();
      return {reset_req_o, vector_service_o, resume_next_o};
   endfunction
   task automatic t_reset();
      #1;
      check("mode", mode_o, 0);
      check("clocks", {cpu_clk_en_o, xtal_en_o}, 2'b11);
      check("periph_en", {sec_en_o, a_en_o, b_en_o, csi_en_o}, 4'hf);
      check("latch", port_latch_o, 8'h00);
      rd(standby_pkg::OFS_SETTLE);
      check("settle_rst", rd_val, 32'h4);
      wr(4'h8, 32'h1);
      rd(4'h8);
      check("unmapped", rd_val, 32'h0);
      rd(standby_pkg::OFS_SETTLE);
      check("settle_kept", rd_val, 32'h4);
   endtask
   task automatic t_halt();
      logic [3:0] cs [6] = '{4'b0000, 4'b0010, 4'b0101, 4'b0110, 4'b0111, 4'b1011};
      logic [2:0] ex [6] = '{3'b001, 3'b010, 3'b001, 3'b001, 3'b010, 3'b000};
      int n;
      for (int i = 0; i < 6; i++) begin
         cpu_u.do_halt();
         #1;
         check("halt_mode", mode_o, standby_pkg::MODE_HALT);
         check("halt_cpu_clk", cpu_clk_en_o, 1'b0);
         cpu_u.post(cs[i]);
         if (ex[i] == 3'b000) begin
            repeat (12) @(posedge ref_clk_i);
            #1;
            check("masked_held", mode_o, standby_pkg::MODE_HALT);
            @(posedge ref_clk_i);
            ext_reset_i <= 1'b1;
            wait_res(n);
            check("halt_rst_wait", n, 1);
            check("halt_rst_kind", res(), 3'b100);
         end else begin
            wait_res(n);
            check("halt_wait", n, (ex[i] == 3'b010) ? 9 : 3);
            check("halt_kind", res(), ex[i]);
            check("halt_clk_back", cpu_clk_en_o, 1'b1);
         end
         cpu_u.clear();
      end
   endtask
   task automatic t_stop_wake();
      int n;
      wr(standby_pkg::OFS_SETTLE, 32'h0);
      rd(standby_pkg::OFS_SETTLE);
      check("settle_wr", rd_val, 32'h0);
      port_wr(8'h5a);
      timer50_run_i <= 1'b1;
      timer_h_sel_tm_i <= 1'b1;
      uart_b_sel_tm_i <= 1'b1;
      cpu_u.do_stop();
      #1;
      check("stop_mode", mode_o, standby_pkg::MODE_STOP);
      check("stop_clocks", {cpu_clk_en_o, xtal_en_o}, 2'b00);
      check("stop_en", {sec_en_o, a_en_o, b_en_o, csi_en_o}, 4'b1010);
      port_wr(8'ha5);
      #1;
      check("latch_hold", port_latch_o, 8'h5a);
      rd(standby_pkg::OFS_STATUS);
      check("status_mode", rd_val & 32'h3, 32'h2);
      cpu_u.post(4'b0010);
      wait_res(n);
      check("stop_wait", n, S + 1);
      check("stop_kind", res(), 3'b010);
      check("xtal_back", xtal_en_o, 1'b1);
      check("latch_after", port_latch_o, 8'h5a);
      cpu_u.clear();
   endtask
   task automatic t_stop_pending();
      int n;
      cpu_u.post(4'b0000);
      stop_seen = 1'b0;
      cpu_u.do_stop();
      wait_res(n);
      check("no_deep", stop_seen, 1'b0);
      check("pend_wait", (n >= S && n <= S + 2), 1'b1);
      check("pend_kind", res(), 3'b001);
      cpu_u.clear();
   endtask
   task automatic t_stop_reset();
      int n;
      timer50_run_i <= 1'b0;
      uart_a_sel_tm_i <= 1'b1;
      csi_sel_ext_i <= 1'b1;
      cpu_u.do_stop();
      repeat (2) @(posedge ref_clk_i);
      #1;
      check("stop_en2", {sec_en_o, a_en_o, b_en_o, csi_en_o}, 4'b0001);
      @(posedge ref_clk_i);
      ext_reset_i <= 1'b1;
      wait_res(n);
      check("stop_rst_wait", n, S + 1);
      check("stop_rst_kind", res(), 3'b100);
   endtask
   initial begin
      repeat (4) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge ref_clk_i);
      t_reset();
      t_halt();
      t_stop_wake();
      t_stop_pending();
      t_stop_reset();
      stop_test();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #20000;
      error_cnt++;
      stop_test();
   end
endmodule
`default_nettype wire
